/* File: hw/vpic_pkg.sv */
// package: constants and types for the vectored priority interrupt controller
// assumes: included before every design file that names vpic_pkg
package vpic_pkg;

	localparam int unsigned        NUM_TRAPS       = 8;
	localparam int unsigned        NUM_TABLE_TRAPS = 7;
	localparam int unsigned        NUM_IRQ         = 246;
	localparam int unsigned        LEVEL_W         = 3;
	localparam int unsigned        VEC_W           = 8;
	localparam int unsigned        ADDR_W          = 24;
	localparam logic [23:0]        TABLE_BASE      = 24'h000004;
	localparam logic [23:0]        RESET_PC        = 24'h000000;
	localparam logic [2:0]         LEVEL_RESET     = 3'h0;
	localparam logic [7:0]         VEC_RESET       = 8'h00;
	// entry and return each take a fixed number of cycles
	localparam int unsigned        ENTRY_CYCLES    = 4;
	localparam int unsigned        RETURN_CYCLES   = 3;
	localparam logic [2:0]         ENTRY_CNT       = 3'(ENTRY_CYCLES - 1);
	localparam logic [2:0]         RETURN_CNT      = 3'(RETURN_CYCLES - 1);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ENTRY,
		ST_SERVICE,
		ST_RETURN
	} seq_state_t;

endpackage : vpic_pkg

/* File: hw/vpic_rank.sv */
// holds: fixed-order priority search over the maskable sources
// assumes: inputs are synchronous to clk; result is combinational
`timescale 1ns/1ps

module vpic_rank #(
	parameter int unsigned N       = 246,
	parameter int unsigned LEVEL_W = 3,
	parameter int unsigned IDX_W   = 8
) (
	input  wire logic [N-1:0]         pend,
	input  wire logic [N*LEVEL_W-1:0] level,
	output logic                      found,
	output logic [IDX_W-1:0]          idx,
	output logic [LEVEL_W-1:0]        best
);

	// walk from the highest index down: lower index wins ties
	always_comb begin
		found = 1'b0;
		idx   = '0;
		best  = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (pend[i] && level[i*LEVEL_W +: LEVEL_W] != '0 &&
			    (!found || level[i*LEVEL_W +: LEVEL_W] >= best)) begin
				found = 1'b1;
				idx   = IDX_W'(i);
				best  = level[i*LEVEL_W +: LEVEL_W];
			end
		end
	end

endmodule : vpic_rank

/* File: hw/vpic_ctrl.sv */
// holds: vectored interrupt controller top, trap arbitration and entry sequence
// assumes: one clock, synchronous reset; the core reads the handler address from
// the vector table at irq_fetch_addr and answers with core_ack / core_ret
//
// Behaviour
// (R01) all peripheral requests merge into one request toward the core
// (R02) up to eight exception and trap sources accepted beside peripherals
// (R03) each maskable source has a software-chosen level among eight
// (R04) every source owns a distinct vector table entry
// (R05) equal levels are resolved by fixed order, never rotating
// (R06) entry and return take a constant cycle count for any source
// (R07) vector table begins at word 000004h; fetch address built from it
// (R08) table holds seven unmaskable trap vectors then up to 246 interrupts
// (R09) each entry gives a 24-bit handler address loaded into the PC
// (R10) lower table position wins; vector zero outranks everything
// (R11) reset bypasses the controller, clears state, PC starts at 0x000000
// (R12) software should fill unused entries with a default resetting handler
// (R13) request only if winner level exceeds core priority; present its vector
// (R14) traps outrank maskable interrupts and ignore enable and masking
`timescale 1ns/1ps

module vpic_ctrl #(
	parameter int unsigned NUM_IRQ   = vpic_pkg::NUM_IRQ,
	parameter int unsigned NUM_TRAPS = vpic_pkg::NUM_TABLE_TRAPS
) (
	input  wire logic                                  clk,
	input  wire logic                                  sys_rst,
	input  wire logic [NUM_IRQ-1:0]                    irq_req,
	input  wire logic [NUM_IRQ-1:0]                    irq_enable,
	input  wire logic [NUM_IRQ*vpic_pkg::LEVEL_W-1:0]  irq_level,
	input  wire logic [NUM_TRAPS-1:0]                  trap_req,
	input  wire logic [vpic_pkg::LEVEL_W-1:0]          core_level,
	input  wire logic                                  core_ack,
	input  wire logic                                  core_ret,
	input  wire logic [vpic_pkg::ADDR_W-1:0]           table_data,
	output logic                                       irq_out_q,
	output logic [vpic_pkg::VEC_W-1:0]                 irq_vector_q,
	output logic [vpic_pkg::ADDR_W-1:0]                irq_fetch_addr_q,
	output logic                                       entry_busy_q,
	output logic                                       pc_load_q,
	output logic [vpic_pkg::ADDR_W-1:0]                pc_value_q,
	output logic [vpic_pkg::LEVEL_W-1:0]               svc_level_q,
	output logic                                       ret_done_q
);

	localparam int unsigned VW = vpic_pkg::VEC_W;
	localparam int unsigned LW = vpic_pkg::LEVEL_W;
	localparam int unsigned AW = vpic_pkg::ADDR_W;
	localparam logic [LW-1:0] TRAP_LEVEL = '1;

	logic [NUM_IRQ-1:0] pend_masked;
	logic               irq_found;
	logic [VW-1:0]      irq_idx;
	logic [LW-1:0]      irq_best;
	logic               trap_found;
	logic [VW-1:0]      trap_idx;
	logic               win_valid;
	logic [VW-1:0]      win_vec;
	logic [LW-1:0]      win_level;
	logic               win_trap;

	vpic_pkg::seq_state_t state_q;
	vpic_pkg::seq_state_t state_d;
	logic [2:0]           cnt_q;
	logic [VW-1:0]        taken_vec_q;
	logic [LW-1:0]        prev_level_q;

	//****************************************************************
	// source ranking
	//****************************************************************

	assign pend_masked = irq_req & irq_enable; // [R01]

	vpic_rank #(
		.N       (NUM_IRQ),
		.LEVEL_W (LW),
		.IDX_W   (VW)
	) u_rank (
		.pend  (pend_masked),
		.level (irq_level),
		.found (irq_found),
		.idx   (irq_idx),
		.best  (irq_best)
	); // [R03] [R05] [R10]

	// lowest trap index wins, no masking applies
	always_comb begin
		trap_found = 1'b0;
		trap_idx   = '0;
		for (int t = NUM_TRAPS - 1; t >= 0; t--) begin
			if (trap_req[t]) begin
				trap_found = 1'b1;
				trap_idx   = VW'(t);
			end
		end
	end // [R02] [R14]

	// traps first in the table, interrupts after them
	always_comb begin
		win_valid = 1'b0;
		win_vec   = '0;
		win_level = '0;
		win_trap  = 1'b0;
		if (trap_found) begin
			win_valid = 1'b1;
			win_vec   = trap_idx;
			win_level = TRAP_LEVEL;
			win_trap  = 1'b1; // [R14]
		end else if (irq_found && irq_best > core_level) begin
			win_valid = 1'b1;
			win_vec   = VW'(irq_idx + VW'(NUM_TRAPS)); // [R04] [R08]
			win_level = irq_best; // [R13]
		end
	end

	//****************************************************************
	// entry and return sequence
	//****************************************************************

	always_comb begin
		state_d = state_q;
		case (state_q)
			vpic_pkg::ST_IDLE: begin
				if (win_valid && core_ack) begin
					state_d = vpic_pkg::ST_ENTRY;
				end
			end
			vpic_pkg::ST_ENTRY: begin
				if (cnt_q == '0) begin
					state_d = vpic_pkg::ST_SERVICE;
				end
			end
			vpic_pkg::ST_SERVICE: begin
				if (core_ret) begin
					state_d = vpic_pkg::ST_RETURN;
				end
			end
			vpic_pkg::ST_RETURN: begin
				if (cnt_q == '0) begin
					state_d = vpic_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = vpic_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= vpic_pkg::ST_IDLE; // [R11]
		end else begin
			state_q <= state_d;
		end
	end

	// fixed counts, no dependence on which source won
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else if (state_q == vpic_pkg::ST_IDLE && state_d == vpic_pkg::ST_ENTRY) begin
			cnt_q <= vpic_pkg::ENTRY_CNT; // [R06]
		end else if (state_q == vpic_pkg::ST_SERVICE && core_ret) begin
			cnt_q <= vpic_pkg::RETURN_CNT; // [R06]
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			taken_vec_q  <= vpic_pkg::VEC_RESET;
			prev_level_q <= vpic_pkg::LEVEL_RESET;
			svc_level_q  <= vpic_pkg::LEVEL_RESET;
		end else if (state_q == vpic_pkg::ST_IDLE && win_valid && core_ack) begin
			taken_vec_q  <= win_vec;
			prev_level_q <= core_level;
			svc_level_q  <= win_level;
		end else if (state_q == vpic_pkg::ST_RETURN && cnt_q == '0) begin
			svc_level_q  <= prev_level_q;
		end
	end

	//****************************************************************
	// outputs toward the core
	//****************************************************************

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_out_q    <= 1'b0;
			irq_vector_q <= vpic_pkg::VEC_RESET;
		end else begin
			irq_out_q    <= win_valid && state_d == vpic_pkg::ST_IDLE
			                && state_q == vpic_pkg::ST_IDLE; // [R01] [R13]
			irq_vector_q <= win_vec; // [R13]
		end
	end

	// word address of the entry for the taken vector
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_fetch_addr_q <= vpic_pkg::TABLE_BASE;
		end else begin
			irq_fetch_addr_q <= vpic_pkg::TABLE_BASE + AW'(taken_vec_q); // [R07]
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			entry_busy_q <= 1'b0;
			pc_load_q    <= 1'b0;
			pc_value_q   <= vpic_pkg::RESET_PC; // [R11]
			ret_done_q   <= 1'b0;
		end else begin
			entry_busy_q <= state_d == vpic_pkg::ST_ENTRY || state_d == vpic_pkg::ST_RETURN;
			pc_load_q    <= state_q == vpic_pkg::ST_ENTRY && cnt_q == '0; // [R06]
			if (state_q == vpic_pkg::ST_ENTRY && cnt_q == '0) begin
				pc_value_q <= table_data; // [R09]
			end
			ret_done_q   <= state_q == vpic_pkg::ST_RETURN && cnt_q == '0; // [R06]
		end
	end

endmodule : vpic_ctrl

/* File: verif/vpic_ctrl_sva.sv */
// checker: port-level properties of vpic_ctrl
// assumes: bound below to every vpic_ctrl; one clock, synchronous reset
`timescale 1ns/1ps
module vpic_ctrl_sva #(
	parameter int unsigned NUM_TRAPS = 7
) (
	input logic			clk,
	input logic			sys_rst,
	input logic [NUM_TRAPS-1:0]	trap_req,
	input logic			core_ack,
	input logic			core_ret,
	input logic [23:0]		table_data,
	input logic			irq_out_q,
	input logic [7:0]		irq_vector_q,
	input logic [23:0]		irq_fetch_addr_q,
	input logic			entry_busy_q,
	input logic			pc_load_q,
	input logic [23:0]		pc_value_q,
	input logic			ret_done_q
);
	logic svc_q;
	logic idle;
	logic take;
	assign take = irq_out_q && core_ack && !entry_busy_q;
	assign idle = !entry_busy_q && !svc_q && !pc_load_q;
	// handler running between load and return
	always_ff @(posedge clk) begin
		if (sys_rst)
			svc_q <= 1'b0;
		else if (pc_load_q)
			svc_q <= 1'b1;
		else if (core_ret)
			svc_q <= 1'b0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_entry; !pc_load_q [*4] ##1 pc_load_q; endsequence
	sequence s_ret; !ret_done_q [*3] ##1 ret_done_q; endsequence
	property p_entry; take |=> s_entry; endproperty
	a_entry: assert property (p_entry) else $error("entry length");
	property p_ret; svc_q && core_ret |=> s_ret; endproperty
	a_ret: assert property (p_ret) else $error("return length");
	property p_fetch;
		take |=> entry_busy_q ##1
			irq_fetch_addr_q == vpic_pkg::TABLE_BASE + 24'($past(irq_vector_q, 2));
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch address");
	property p_pc; pc_load_q |-> pc_value_q == $past(table_data); endproperty
	a_pc: assert property (p_pc) else $error("handler address");
	property p_pulse; pc_load_q |=> !pc_load_q; endproperty
	a_pulse: assert property (p_pulse) else $error("load pulse");
	property p_busy; entry_busy_q |-> !irq_out_q; endproperty
	a_busy: assert property (p_busy) else $error("request while busy");
	property p_trap; (idle && trap_req[0]) [*3] |-> irq_out_q && irq_vector_q == 8'h00; endproperty
	a_trap: assert property (p_trap) else $error("trap not first");
	property p_rst;
		$past(sys_rst) |-> irq_fetch_addr_q == vpic_pkg::TABLE_BASE &&
			pc_value_q == vpic_pkg::RESET_PC && !irq_out_q;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
endmodule : vpic_ctrl_sva
bind vpic_ctrl vpic_ctrl_sva #(.NUM_TRAPS(NUM_TRAPS)) sva_inst (.clk, .sys_rst, .trap_req,
	.core_ack, .core_ret, .table_data, .irq_out_q, .irq_vector_q, .irq_fetch_addr_q,
	.entry_busy_q, .pc_load_q, .pc_value_q, .ret_done_q);

/* File: verif/core_model.sv */
// partner: behavioural processor core with its vector table
// assumes: shares clk and sys_rst with the controller
`timescale 1ns/1ps
module core_model #(
	parameter int unsigned RET_WAIT = 5
) (
	input logic		clk,
	input logic		sys_rst,
	input logic		ack_en,
	input logic		irq_out_q,
	input logic [23:0]	fetch_addr,
	input logic		pc_load_q,
	output logic		core_ack,
	output logic		core_ret,
	output logic [23:0]	table_data
);
	logic [3:0] wait_q;
	// entries at 000100h and above point at a resetting default handler at 000200h
	assign table_data = (fetch_addr < 24'h000100) ? {fetch_addr[15:0], 8'ha5} : 24'h000200;
	always_ff @(posedge clk) begin
		core_ack <= irq_out_q && ack_en && !sys_rst;
		core_ret <= (wait_q == 4'h1);
		if (sys_rst)
			wait_q <= 4'h0;
		else if (pc_load_q)
			wait_q <= 4'(RET_WAIT);
		else if (wait_q != 4'h0)
			wait_q <= wait_q - 4'h1;
	end
endmodule : core_model

/* File: verif/tb_top.sv */
// bench: directed scenarios for vpic_ctrl against a core model
// assumes: vpic_pkg compiled first; eight maskable sources
`timescale 1ns/1ps
module tb_top;
	logic		clk = 1'b0;
	logic		sys_rst = 1'b1;
	logic [7:0]	irq_req = 8'h00;
	logic [7:0]	irq_enable = 8'hff;
	logic [23:0]	irq_level = 24'h000000;
	logic [6:0]	trap_req = 7'h00;
	logic [2:0]	core_level = 3'h0;
	logic		ack_en = 1'b0;
	logic		core_ack, core_ret, irq_out_q, entry_busy_q, pc_load_q, ret_done_q;
	logic [23:0]	table_data, irq_fetch_addr_q, pc_value_q;
	logic [7:0]	irq_vector_q;
	logic [2:0]	svc_level_q;
	int		errors = 0;
	int		n_tests = 0;
	int		lat0 = -1;
	always #50 clk = ~clk;
	vpic_ctrl #(.NUM_IRQ(8), .NUM_TRAPS(7)) vpic_ctrl_inst (.clk, .sys_rst, .irq_req,
		.irq_enable, .irq_level, .trap_req, .core_level, .core_ack, .core_ret, .table_data,
		.irq_out_q, .irq_vector_q, .irq_fetch_addr_q, .entry_busy_q, .pc_load_q,
		.pc_value_q, .svc_level_q, .ret_done_q);
	core_model core_model_inst (.clk, .sys_rst, .ack_en, .irq_out_q,
		.fetch_addr(irq_fetch_addr_q), .pc_load_q, .core_ack, .core_ret, .table_data);
	task automatic print_verdict();
		if (errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tmo(input int n);
		if (n >= 20) begin
			errors++;
			print_verdict();
		end
	endtask : tmo
	task automatic raise(input int i, input logic [2:0] l);
		@(posedge clk);
		irq_req[i] <= 1'b1;
		irq_level[3*i +: 3] <= l;
	endtask : raise
	// take the pending winner, follow entry and return, time both
	task automatic serve(input logic [7:0] vec, input logic [2:0] lvl);
		logic [23:0] a;
		int n;
		int lat;
		a = 24'h000004 + 24'(vec);
		n = 0;
		lat = 0;
		repeat (3) @(negedge clk);
		while (irq_out_q !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		tmo(n);
		check(irq_vector_q, vec);
		@(posedge clk);
		ack_en <= 1'b1;
		while (pc_load_q !== 1'b1 && lat < 20) begin
			@(negedge clk);
			lat++;
		end
		tmo(lat);
		check(irq_fetch_addr_q, a);
		check(pc_value_q, {a[15:0], 8'ha5});
		check(24'(svc_level_q), 24'(lvl));
		@(posedge clk);
		ack_en <= 1'b0;
		irq_req <= 8'h00;
		trap_req <= 7'h00;
		n = 0;
		while (ret_done_q !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		tmo(n);
		check(24'(svc_level_q), 24'(core_level));
		lat = lat + n;
		if (lat0 < 0)
			lat0 = lat;
		check(24'(lat), 24'(lat0));
	endtask : serve
	task automatic s_walk();
		raise(3, 3'h5);
		serve(8'h0a, 3'h5);
	endtask : s_walk
	task automatic s_trap();
		raise(0, 3'h7);
		trap_req <= 7'h45;
		core_level <= 3'h7;
		serve(8'h00, 3'h7);
		core_level <= 3'h0;
	endtask : s_trap
	task automatic s_tie();
		raise(5, 3'h4);
		raise(1, 3'h4);
		serve(8'h08, 3'h4);
	endtask : s_tie
	task automatic s_level();
		raise(0, 3'h2);
		raise(6, 3'h6);
		serve(8'h0d, 3'h6);
	endtask : s_level
	task automatic s_mask();
		core_level <= 3'h3;
		irq_enable <= 8'hef;
		raise(2, 3'h3);
		raise(4, 3'h7);
		repeat (5) begin
			@(negedge clk);
			check(irq_out_q, 1'b0);
		end
		core_level <= 3'h2;
		serve(8'h09, 3'h3);
		irq_enable <= 8'hff;
	endtask : s_mask
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		check(irq_fetch_addr_q, 24'h000004);
		check(pc_value_q, 24'h000000);
		s_walk();
		s_trap();
		s_tie();
		s_level();
		s_mask();
		print_verdict();
	end
endmodule : tb_top
